// file: pipt_pkg.sv
// ************************************************************
// Register map and field layout
// ************************************************************
package pipt_pkg;

  localparam int unsigned PIPT_ADDR_W = 12;
  localparam int unsigned PIPT_DATA_W = 32;
  localparam int unsigned PIPT_REG_W = 8;
  localparam int unsigned PIPT_PAD_W = PIPT_DATA_W - PIPT_REG_W;

  localparam logic [PIPT_ADDR_W-1:0] PIPT_LEVEL_OFFSET = 12'h000;
  localparam logic [PIPT_ADDR_W-1:0] PIPT_CTRL_OFFSET = 12'h004;
  localparam logic [PIPT_ADDR_W-1:0] PIPT_STATUS_OFFSET = 12'h008;

  // Level select fields
  localparam int unsigned PIPT_BIT_OSC_FAIL = 7;
  localparam int unsigned PIPT_BIT_COMPARATOR = 6;
  localparam int unsigned PIPT_BIT_UNUSED = 5;
  localparam int unsigned PIPT_BIT_NVM_WRITE = 4;
  localparam int unsigned PIPT_BIT_BUS_COLLISION = 3;
  localparam int unsigned PIPT_BIT_LOW_VOLTAGE = 2;
  localparam int unsigned PIPT_BIT_TIMER_THREE = 1;
  localparam int unsigned PIPT_BIT_CAPTURE_TWO = 0;

  localparam logic [PIPT_REG_W-1:0] PIPT_LEVEL_RESET = 8'hdf;
  localparam logic [PIPT_REG_W-1:0] PIPT_LEVEL_MASK = 8'hdf;

  // Control fields
  localparam int unsigned PIPT_BIT_PRIO_ENABLE = 7;
  localparam logic PIPT_PRIO_ENABLE_RESET = 1'b0;

  // Status fields
  localparam int unsigned PIPT_BIT_STAT_HIGH = 0;
  localparam int unsigned PIPT_BIT_STAT_LOW = 1;

endpackage : pipt_pkg

// file: pipt_steer.sv
`timescale 1ns/1ps
// ************************************************************
// Routes pending sources onto the two request levels
// ************************************************************
module pipt_steer #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] pending_in,
  input wire logic [WIDTH-1:0] level_in,
  input wire logic enable_in,
  output logic high_out,
  output logic low_out
);

  always_comb
  begin
    if (enable_in)
    begin
      high_out = |(pending_in & level_in);
      low_out = |(pending_in & ~level_in);
    end
    else
    begin
      // Single-level mode: every source shares the one vector
      high_out = |pending_in;
      low_out = 1'b0;
    end
  end

endmodule : pipt_steer

// file: pipt_level_regs.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 4 puts the memory write-done source at high level when one.
// - Bit 3 puts the bus collision source at high level when one.
// - Bit 2 puts the low-voltage source at high level when one.
// - Bit 1 puts the third timer overflow source at high level when one.
// - Levels apply only while the priority enable is set, else one level.
module pipt_level_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [pipt_pkg::PIPT_ADDR_W-1:0] paddr_in,
  input wire logic [pipt_pkg::PIPT_DATA_W-1:0] pwdata_in,
  output logic [pipt_pkg::PIPT_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [pipt_pkg::PIPT_REG_W-1:0] source_pending_in,
  output logic [pipt_pkg::PIPT_REG_W-1:0] level_select_out,
  output logic priority_levels_enable_out,
  output logic high_req_out,
  output logic low_req_out
);
  import pipt_pkg::*;

  // ************************************************************
  // Register state
  // ************************************************************
  logic osc_fail_level;
  logic comparator_level;
  logic nvm_write_level;
  logic bus_collision_level;
  logic low_voltage_level;
  logic timer_three_overflow_level;
  logic capture_compare_two_level;
  logic priority_levels_enable;

  logic [PIPT_REG_W-1:0] peripheral_irq_level_select_two;
  logic [PIPT_REG_W-1:0] ctrl_value;
  logic [PIPT_REG_W-1:0] status_value;
  logic [PIPT_REG_W-1:0] pending_used;
  logic next_high;
  logic next_low;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic access;
  logic commit;
  logic hit_level;
  logic hit_ctrl;
  logic hit_status;
  logic mapped;

  // Answer one cycle into the access phase, so reads come from flops
  assign access = psel_in & penable_in;
  assign commit = access & pready_out;
  assign hit_level = (paddr_in == PIPT_LEVEL_OFFSET);
  assign hit_ctrl = (paddr_in == PIPT_CTRL_OFFSET);
  assign hit_status = (paddr_in == PIPT_STATUS_OFFSET);
  assign mapped = hit_level | hit_ctrl | hit_status;

  // ************************************************************
  // Level select register
  // ************************************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      osc_fail_level <= PIPT_LEVEL_RESET[PIPT_BIT_OSC_FAIL];
      comparator_level <= PIPT_LEVEL_RESET[PIPT_BIT_COMPARATOR];
      nvm_write_level <= PIPT_LEVEL_RESET[PIPT_BIT_NVM_WRITE];
      bus_collision_level <= PIPT_LEVEL_RESET[PIPT_BIT_BUS_COLLISION];
      low_voltage_level <= PIPT_LEVEL_RESET[PIPT_BIT_LOW_VOLTAGE];
      timer_three_overflow_level <= PIPT_LEVEL_RESET[PIPT_BIT_TIMER_THREE];
      capture_compare_two_level <= PIPT_LEVEL_RESET[PIPT_BIT_CAPTURE_TWO];
    end
    else if (commit && pwrite_in && hit_level)
    begin
      osc_fail_level <= pwdata_in[PIPT_BIT_OSC_FAIL];
      comparator_level <= pwdata_in[PIPT_BIT_COMPARATOR];
      nvm_write_level <= pwdata_in[PIPT_BIT_NVM_WRITE];
      bus_collision_level <= pwdata_in[PIPT_BIT_BUS_COLLISION];
      low_voltage_level <= pwdata_in[PIPT_BIT_LOW_VOLTAGE];
      timer_three_overflow_level <= pwdata_in[PIPT_BIT_TIMER_THREE];
      capture_compare_two_level <= pwdata_in[PIPT_BIT_CAPTURE_TWO];
    end
  end

  // Unused bit 5 is a constant zero, so writes to it vanish
  always_comb
  begin
    peripheral_irq_level_select_two = '0;
    peripheral_irq_level_select_two[PIPT_BIT_OSC_FAIL] = osc_fail_level;
    peripheral_irq_level_select_two[PIPT_BIT_COMPARATOR] = comparator_level;
    peripheral_irq_level_select_two[PIPT_BIT_UNUSED] = 1'b0;
    peripheral_irq_level_select_two[PIPT_BIT_NVM_WRITE] = nvm_write_level;
    peripheral_irq_level_select_two[PIPT_BIT_BUS_COLLISION] =
      bus_collision_level;
    peripheral_irq_level_select_two[PIPT_BIT_LOW_VOLTAGE] = low_voltage_level;
    peripheral_irq_level_select_two[PIPT_BIT_TIMER_THREE] =
      timer_three_overflow_level;
    peripheral_irq_level_select_two[PIPT_BIT_CAPTURE_TWO] =
      capture_compare_two_level;
  end

  // ************************************************************
  // Control register
  // ************************************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      priority_levels_enable <= PIPT_PRIO_ENABLE_RESET;
    end
    else if (commit && pwrite_in && hit_ctrl)
    begin
      priority_levels_enable <= pwdata_in[PIPT_BIT_PRIO_ENABLE];
    end
  end

  always_comb
  begin
    ctrl_value = '0;
    ctrl_value[PIPT_BIT_PRIO_ENABLE] = priority_levels_enable;
  end

  // ************************************************************
  // Request steering
  // ************************************************************
  // A pending line on the unused position must never raise a request
  assign pending_used = source_pending_in & PIPT_LEVEL_MASK;

  pipt_steer #(
    .WIDTH(PIPT_REG_W)
  ) u_steer (
    .pending_in(pending_used),
    .level_in(peripheral_irq_level_select_two),
    .enable_in(priority_levels_enable),
    .high_out(next_high),
    .low_out(next_low)
  );

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      high_req_out <= 1'b0;
      low_req_out <= 1'b0;
    end
    else
    begin
      high_req_out <= next_high;
      low_req_out <= next_low;
    end
  end

  always_comb
  begin
    status_value = '0;
    status_value[PIPT_BIT_STAT_HIGH] = high_req_out;
    status_value[PIPT_BIT_STAT_LOW] = low_req_out;
  end

  // ************************************************************
  // Mirrored outputs
  // ************************************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      level_select_out <= PIPT_LEVEL_RESET;
      priority_levels_enable_out <= PIPT_PRIO_ENABLE_RESET;
    end
    else
    begin
      level_select_out <= peripheral_irq_level_select_two;
      priority_levels_enable_out <= priority_levels_enable;
    end
  end

  // ************************************************************
  // Bus answer
  // ************************************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= access & ~pready_out;
      pslverr_out <= access & ~pready_out & ~mapped;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_out <= '0;
    end
    else if (access && !pready_out && !pwrite_in)
    begin
      if (hit_level)
      begin
        prdata_out <= {{PIPT_PAD_W{1'b0}}, peripheral_irq_level_select_two};
      end
      else if (hit_ctrl)
      begin
        prdata_out <= {{PIPT_PAD_W{1'b0}}, ctrl_value};
      end
      else if (hit_status)
      begin
        prdata_out <= {{PIPT_PAD_W{1'b0}}, status_value};
      end
      else
      begin
        prdata_out <= '0;
      end
    end
    else
    begin
      prdata_out <= '0;
    end
  end

endmodule : pipt_level_regs

// file: pipt_level_regs_assertions.sv
`timescale 1ns/1ps
// ****
// Steering and level reset value checks
// ****
module pipt_level_regs_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic [7:0] source_pending_in,
  input wire logic [7:0] level_select_out,
  input wire logic priority_levels_enable_out,
  input wire logic high_req_out,
  input wire logic low_req_out
);
  wire logic q = !psel_in;
  wire logic en = priority_levels_enable_out;
  wire logic [7:0] p = source_pending_in;
  wire logic [7:0] l = level_select_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Two quiet cycles so no write lands inside the window
  nvm_high_a: assert property ((q && en && l[4] && p == 8'h10)[*2]
    |=> high_req_out && !low_req_out) else $error("nvm not high");
  bus_coll_a: assert property ((q && en && !l[3] && p == 8'h08)[*2]
    |=> low_req_out && !high_req_out) else $error("collision not low");
  low_volt_a: assert property ((q && en && p == 8'h04)[*2]
    |=> high_req_out == $past(l[2])) else $error("low voltage level");
  timer_three_a: assert property ((q && en && p == 8'h02)[*2]
    |=> low_req_out != $past(l[1])) else $error("timer level");
  unused_src_a: assert property ((q && p == 8'h20)[*2]
    |=> !high_req_out && !low_req_out) else $error("unused source");
  reset_value_a: assert property ($fell(rst_in) |-> l == 8'hdf)
    else $error("level reset value");
  single_level_a: assert property ((q && !en)[*2] |=> !low_req_out
    && high_req_out == |($past(p) & 8'hdf)) else $error("single level");
endmodule : pipt_level_regs_checker

bind pipt_level_regs pipt_level_regs_checker u_chk (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .psel_in(psel_in),
  .source_pending_in(source_pending_in),
  .level_select_out(level_select_out),
  .priority_levels_enable_out(priority_levels_enable_out),
  .high_req_out(high_req_out),
  .low_req_out(low_req_out)
);

// file: pipt_level_regs_tb.sv
`timescale 1ns/1ps
module pipt_level_regs_tb;
  import pipt_pkg::*;
  typedef struct packed {
    logic en;
    logic [7:0] lvl;
    logic [7:0] pend;
    logic [1:0] hl;
  } pipt_row_type;
  logic clk_in, rst_in, psel_in, penable_in, pwrite_in, er;
  logic pready_out, pslverr_out, high_req_out, low_req_out, prio_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [7:0] source_pending_in, level_select_out;
  int err_count, n_tests;
  // ****
  // Rows: enable, levels, pending, {high, low}
  // ****
  pipt_row_type rows [14] = '{'{1'h1, 8'hdf, 8'h10, 2'h2},
    '{1'h1, 8'hef, 8'h10, 2'h1}, '{1'h1, 8'hdf, 8'h08, 2'h2},
    '{1'h1, 8'hf7, 8'h08, 2'h1}, '{1'h1, 8'hdf, 8'h04, 2'h2},
    '{1'h1, 8'hfb, 8'h04, 2'h1}, '{1'h1, 8'hdf, 8'h02, 2'h2},
    '{1'h1, 8'hfd, 8'h02, 2'h1}, '{1'h1, 8'h5f, 8'h80, 2'h1},
    '{1'h1, 8'h9f, 8'h40, 2'h1}, '{1'h1, 8'hde, 8'h01, 2'h1},
    '{1'h1, 8'hdf, 8'h20, 2'h0}, '{1'h0, 8'h00, 8'h18, 2'h2},
    '{1'h0, 8'hdf, 8'h00, 2'h0}};

  pipt_level_regs u_dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .source_pending_in(source_pending_in),
    .level_select_out(level_select_out),
    .priority_levels_enable_out(prio_out),
    .high_req_out(high_req_out),
    .low_req_out(low_req_out)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Slave wait is not assumed; the watchdog bounds it
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task results;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  initial
  begin
    #20000;
    err_count++;
    results;
  end

  initial
  begin
    {rst_in, psel_in, penable_in, pwrite_in} = 4'h8;
    {paddr_in, pwdata_in, source_pending_in} = '0;
    repeat (10) @(posedge clk_in);
    chk("ready in reset", 32'(pready_out), 32'h0);
    chk("level in reset", 32'(level_select_out), 32'hdf);
    chk("enable out in reset", 32'(prio_out), 32'h0);
    rst_in <= 1'b0;
    apb(1'b0, PIPT_LEVEL_OFFSET, 32'h0);
    chk("level reset", rd, 32'hdf);
    apb(1'b0, PIPT_CTRL_OFFSET, 32'h0);
    chk("enable reset", rd, 32'h0);
    foreach (rows[i])
    begin
      apb(1'b1, PIPT_CTRL_OFFSET, {24'h0, rows[i].en, 7'h0});
      apb(1'b1, PIPT_LEVEL_OFFSET, {24'h0, rows[i].lvl});
      source_pending_in <= rows[i].pend;
      repeat (3) @(posedge clk_in);
      chk("req", 32'({high_req_out, low_req_out}),
        32'(rows[i].hl));
      chk("enable out", 32'(prio_out), 32'(rows[i].en));
      chk("level out", 32'(level_select_out),
        32'(rows[i].lvl & PIPT_LEVEL_MASK));
    end
    apb(1'b1, PIPT_LEVEL_OFFSET, 32'hffffffff);
    apb(1'b0, PIPT_LEVEL_OFFSET, 32'h0);
    chk("level rw", rd, 32'hdf);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    // Single-level mode: every pending source except unused bit 5 lands on the high request
    source_pending_in <= 8'h10;
    apb(1'b1, PIPT_STATUS_OFFSET, 32'hffffffff);
    chk("status write err", {31'h0, er}, 32'h0);
    apb(1'b0, PIPT_STATUS_OFFSET, 32'h0);
    chk("status single", rd, 32'h1);
    apb(1'b1, PIPT_LEVEL_OFFSET, 32'h0);
    apb(1'b1, PIPT_CTRL_OFFSET, 32'h80);
    apb(1'b0, PIPT_STATUS_OFFSET, 32'h0);
    chk("status low", rd, 32'h2);
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    apb(1'b0, PIPT_LEVEL_OFFSET, 32'h0);
    chk("level rereset", rd, 32'hdf);
    chk("level out rereset", 32'(level_select_out), 32'hdf);
    apb(1'b0, PIPT_CTRL_OFFSET, 32'h0);
    chk("enable rereset", rd, 32'h0);
    chk("enable out rereset", 32'(prio_out), 32'h0);
    results;
  end
endmodule : pipt_level_regs_tb
